// ### bench/mac_side_model.sv
// mac-side pin model: strap resistors and shared pin resolution
`timescale 1ns/1ps
`default_nettype none
module mac_side_model (
  // pins from the device
  input  wire mii_strap_pkg::strap_pins_t pinOut,
  input  wire mii_strap_pkg::strap_pins_t pinOe,
  // strap resistor levels
  input  wire mii_strap_pkg::strap_pins_t strapLevel,
  // resolved pin levels
  output mii_strap_pkg::strap_pins_t      pinLevel
);
  // ***************************
  // pin resolution
  // ***************************
  // released pins fall to their resistor level, never to a stale value
  assign pinLevel = (pinOut & pinOe) | (strapLevel & ~pinOe);
  // no management traffic: the model is purely combinational and takes no clock
endmodule
`default_nettype wire

// ### bench/mii_pin_strap_config_tb.sv
// self-checking bench for the strap loader
`timescale 1ns/1ps
`default_nettype none
module mii_pin_strap_config_tb;
  // ***************************
  // signals
  // ***************************
  typedef struct packed {
    logic [7:0]  pins;
    logic [4:0]  addr;
    logic [15:0] ctrl;
    logic [2:0]  mode;
    logic [7:0]  oe;
  } row_t;
  logic                         ref_clk;
  logic                         rstn;
  wire mii_strap_pkg::strap_pins_t pinIn;
  mii_strap_pkg::strap_pins_t   pinOut;
  mii_strap_pkg::strap_pins_t   pinOe;
  mii_strap_pkg::strap_pins_t   rxSource;
  mii_strap_pkg::strap_pins_t   strapLevel;
  mii_strap_pkg::mii_tx_t       txWord;
  mii_strap_pkg::iface_mode_t   interfaceMode;
  logic                         rxClk;
  logic                         txClk;
  logic                         txEnPin;
  logic [3:0]                   txDataPin;
  logic                         txWordValid;
  logic                         strapDone;
  logic [4:0]                   stationAddress;
  logic [15:0]                  basicControl;
  logic                         modeReserved;
  logic [7:0]                   intEnable;
  logic [7:0]                   intEvents;
  logic [7:0]                   intClear;
  logic                         intPolarityHigh;
  logic [7:0]                   intPending;
  logic                         interruptPin;
  logic                         seenClk;
  int                           error_cnt;
  int                           n_compared;
  int                           vcnt;
  // strap byte {rxd3..rxd0, rxdv, rxer, crs, col}
  row_t rows [9] = '{
    '{8'h80, 5'h01, 16'h0000, 3'h0, 8'hff}, '{8'h71, 5'h06, 16'h0100, 3'h1, 8'h00},
    '{8'hf2, 5'h07, 16'h0100, 3'h2, 8'h00}, '{8'h03, 5'h00, 16'h0000, 3'h3, 8'h00},
    '{8'h88, 5'h01, 16'h0000, 3'h4, 8'hff}, '{8'h49, 5'h02, 16'h0000, 3'h5, 8'h00},
    '{8'h1a, 5'h00, 16'h0100, 3'h6, 8'hff}, '{8'h8f, 5'h01, 16'h0400, 3'h7, 8'h00},
    '{8'h8c, 5'h01, 16'h0400, 3'h4, 8'h00}};
  // ***************************
  // instances
  // ***************************
  mii_pin_strap_config mii_pin_strap_config_i (
    .ref_clk(ref_clk), .rstn(rstn), .pinIn(pinIn), .pinOut(pinOut), .pinOe(pinOe),
    .rxClk(rxClk), .txClk(txClk), .txEnPin(txEnPin), .txDataPin(txDataPin),
    .rxSource(rxSource), .txWord(txWord), .txWordValid(txWordValid), .strapDone(strapDone),
    .stationAddress(stationAddress), .basicControl(basicControl),
    .interfaceMode(interfaceMode), .modeReserved(modeReserved), .intEnable(intEnable),
    .intEvents(intEvents), .intClear(intClear), .intPolarityHigh(intPolarityHigh),
    .intPending(intPending), .interruptPin(interruptPin));
  mac_side_model mac_side_model_i (
    .pinOut(pinOut), .pinOe(pinOe), .strapLevel(strapLevel), .pinLevel(pinIn));
  always #50 ref_clk = ~ref_clk;
  // ***************************
  // tasks
  // ***************************
  task check(input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[FAIL] %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task print_verdict;
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task do_reset(input logic [7:0] s);
    strapLevel = s;
    rstn = 1'b0;
    repeat (3) @(negedge ref_clk);
    check({8'h00, pinOe}, 16'h0000);
    check({15'h0, strapDone}, 16'h0000);
    check({11'h0, stationAddress}, 16'h0001);
    check(basicControl, 16'h0100);
    rstn = 1'b1;
    for (int k = 0; k < 10 && strapDone !== 1'b1; k++) @(negedge ref_clk);
    if (strapDone !== 1'b1) begin
      error_cnt++;
      print_verdict();
    end
  endtask
  // ***************************
  // sequence
  // ***************************
  initial begin
    ref_clk = 1'b0;
    rstn = 1'b0;
    rxSource = 8'h00;
    txEnPin = 1'b0;
    txDataPin = 4'h0;
    intEnable = 8'h00;
    intEvents = 8'h00;
    intClear = 8'h00;
    intPolarityHigh = 1'b0;
    strapLevel = 8'h80;
    error_cnt = 0;
    n_compared = 0;
    foreach (rows[i]) begin
      do_reset(rows[i].pins);
      check({11'h0, stationAddress}, {11'h0, rows[i].addr});
      check(basicControl, rows[i].ctrl);
      check({13'h0, interfaceMode}, {13'h0, rows[i].mode});
      check({15'h0, modeReserved}, {15'h0, &rows[i].mode[1:0]});
      @(negedge ref_clk);
      check({8'h00, pinOe}, {8'h00, rows[i].oe});
      strapLevel = ~rows[i].pins;
      repeat (4) @(negedge ref_clk);
      check({11'h0, stationAddress}, {11'h0, rows[i].addr});
      check(basicControl, rows[i].ctrl);
    end
    do_reset(8'h80);
    @(negedge ref_clk);
    rxSource = 8'ha5;
    seenClk = rxClk;
    @(negedge ref_clk);
    check({8'h00, pinIn}, 16'h00a5);
    check({15'h0, rxClk}, {15'h0, ~seenClk});
    check({15'h0, txClk}, {15'h0, rxClk});
    rxSource = 8'h3c;
    @(negedge ref_clk);
    check({8'h00, pinIn}, 16'h003c);
    vcnt = 0;
    txEnPin = 1'b1;
    txDataPin = 4'h9;
    for (int k = 0; k < 8; k++) begin
      if (k == 1) txDataPin = 4'h3;
      if (k == 2) begin
        txEnPin = 1'b0;
        txDataPin = 4'hc;
      end
      @(negedge ref_clk);
      if (txWordValid === 1'b1) vcnt++;
    end
    check(vcnt[15:0], 16'h0002);
    check({11'h0, txWord}, 16'h0013);
    intEnable = 8'h05;
    intEvents = 8'h07;
    @(negedge ref_clk);
    intEvents = 8'h00;
    check({8'h00, intPending}, 16'h0005);
    check({15'h0, interruptPin}, 16'h0001);
    @(negedge ref_clk);
    check({15'h0, interruptPin}, 16'h0000);
    intPolarityHigh = 1'b1;
    repeat (2) @(negedge ref_clk);
    check({15'h0, interruptPin}, 16'h0001);
    intClear = 8'h05;
    intEvents = 8'h04;
    @(negedge ref_clk);
    intClear = 8'h00;
    intEvents = 8'h00;
    check({8'h00, intPending}, 16'h0004);
    intClear = 8'h04;
    @(negedge ref_clk);
    intClear = 8'h00;
    @(negedge ref_clk);
    check({8'h00, intPending}, 16'h0000);
    check({15'h0, interruptPin}, 16'h0000);
    print_verdict();
  end
endmodule
`default_nettype wire

// ### logic/mii_pin_strap_config.sv
// strap loader and dual-role mii pin control
//
// Behaviour
// RULE_01: at reset release receive data lines 3, 2 and 1 become station address bits 0, 1 and 2.
// RULE_02: at reset release receive data line 0 is loaded as the duplex bit, bit 8 of control register 0h.
// RULE_03: at reset release the receive-data-valid pin is loaded as the mode strap msb.
// RULE_04: at reset release the receive-error pin is loaded as the bus detach strap.
// RULE_05: the interrupt pin is active low unless bit 9 of register 1Fh selects high polarity.
// RULE_06: register 1Bh enables interrupt conditions and reports which of them are pending.
// RULE_07: the management controller supplies the management clock and times data to it; the code has no management interface.
// RULE_08: in mii mode the receive clock, data, valid and error pins are driven after reset.
// RULE_09: in mii mode the transmit clock is driven and transmit enable and data are inputs.
// RULE_10: mode strap 000 mii, 001 rmii, 010 smii, 100/101/110 variants, 011 and 111 reserved.
// RULE_11: the detach strap lands in bit 10 of control register 0h, high enables it.
// RULE_12: station address bits 4 and 3 are always zero, giving addresses 0 to 7.
// RULE_13: transmit data is taken only while transmit enable is high.
// RULE_14: strap pins stay undriven in reset, are captured once after release, then driven; the code drives them only in mii modes with detach low.
`timescale 1ns/1ps
`default_nettype none
module mii_pin_strap_config (
  // clock and reset
  input  wire logic                       ref_clk,
  input  wire logic                       rstn,
  // dual-role receive pins
  input  wire mii_strap_pkg::strap_pins_t pinIn,
  output mii_strap_pkg::strap_pins_t      pinOut,
  output mii_strap_pkg::strap_pins_t      pinOe,
  output logic                            rxClk,
  // transmit pins
  output logic                            txClk,
  input  wire logic                       txEnPin,
  input  wire logic [3:0]                 txDataPin,
  // core side
  input  wire mii_strap_pkg::strap_pins_t rxSource,
  output mii_strap_pkg::mii_tx_t          txWord,
  output logic                            txWordValid,
  // configuration results
  output logic                            strapDone,
  output logic [4:0]                      stationAddress,
  output logic [15:0]                     basicControl,
  output mii_strap_pkg::iface_mode_t      interfaceMode,
  output logic                            modeReserved,
  // interrupt
  input  wire logic [7:0]                 intEnable,
  input  wire logic [7:0]                 intEvents,
  input  wire logic [7:0]                 intClear,
  input  wire logic                       intPolarityHigh,
  output logic [7:0]                      intPending,
  output logic                            interruptPin
);
  // ***************************
  // synchronised pins
  // ***************************
  mii_strap_pkg::strap_pins_t syncPins;
  logic                       syncTxEn;
  logic [3:0]                 syncTxData;
  logic [12:0]                syncOut;

  strap_sync #(.WIDTH(13)) u_sync (
    .ref_clk (ref_clk),
    .rstn    (rstn),
    .din     ({pinIn, txEnPin, txDataPin}),
    .dout    (syncOut)
  );
  assign {syncPins, syncTxEn, syncTxData} = syncOut;

  // ***************************
  // strap sequencer
  // ***************************
  typedef enum logic {SEQ_SETTLE, SEQ_RUN} seq_state_t;
  seq_state_t                state;
  seq_state_t                next_state;
  logic [3:0]                settleCount;
  logic [3:0]                next_settleCount;
  mii_strap_pkg::strap_cfg_t cfg;
  mii_strap_pkg::strap_cfg_t next_cfg;
  logic [15:0]               next_basicControl;
  logic                      next_modeReserved;
  logic                      next_strapDone;

  always_comb begin
    next_state        = state;
    next_settleCount  = settleCount;
    next_cfg          = cfg;
    next_strapDone    = strapDone;
    next_modeReserved = modeReserved;
    next_basicControl = basicControl;
    unique case (state)
      SEQ_SETTLE: begin
        if (settleCount == 4'(mii_strap_pkg::SETTLE_CYCLES - 1)) begin
          next_cfg.stationAddress = {2'b00, syncPins.rxd[1], syncPins.rxd[2],
                                     syncPins.rxd[3]};                    // [RULE_01] [RULE_12]
          next_cfg.duplex         = syncPins.rxd[0];                     // [RULE_02]
          next_cfg.mode           = mii_strap_pkg::iface_mode_t'(
                                    {syncPins.rxdv, syncPins.crs, syncPins.col}); // [RULE_03]
          next_cfg.detach         = syncPins.rxer;                       // [RULE_04]
          next_basicControl       = 16'h0000;
          next_basicControl[mii_strap_pkg::DUPLEX_BIT] = syncPins.rxd[0]; // [RULE_02]
          next_basicControl[mii_strap_pkg::DETACH_BIT] = syncPins.rxer;   // [RULE_11]
          next_modeReserved = (next_cfg.mode == mii_strap_pkg::MODE_RSVD3) ||
                              (next_cfg.mode == mii_strap_pkg::MODE_RSVD7); // [RULE_10]
          next_strapDone    = 1'b1;                                      // [RULE_14]
          next_state        = SEQ_RUN;
        end else begin
          next_settleCount = settleCount + 4'h1;
        end
      end
      SEQ_RUN: begin
        next_state = SEQ_RUN;
      end
    endcase
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      state        <= SEQ_SETTLE;
      settleCount  <= 4'h0;
      cfg          <= mii_strap_pkg::STRAP_RESET;
      strapDone    <= 1'b0;
      modeReserved <= 1'b0;
      basicControl <= mii_strap_pkg::CTRL_RESET;
    end else begin
      state        <= next_state;
      settleCount  <= next_settleCount;
      cfg          <= next_cfg;
      strapDone    <= next_strapDone;
      modeReserved <= next_modeReserved;
      basicControl <= next_basicControl;
    end
  end

  assign stationAddress = cfg.stationAddress;
  assign interfaceMode  = cfg.mode;

  // ***************************
  // mii pin drive and transmit capture
  // ***************************
  logic                       miiActive;
  mii_strap_pkg::strap_pins_t next_pinOut;
  mii_strap_pkg::strap_pins_t next_pinOe;
  logic                       next_rxClk;
  logic                       next_txClk;
  mii_strap_pkg::mii_tx_t     next_txWord;
  logic                       next_txWordValid;

  assign miiActive = strapDone && !cfg.detach &&
                     (cfg.mode == mii_strap_pkg::MODE_MII ||
                      cfg.mode == mii_strap_pkg::MODE_MII_PREAMBLE ||
                      cfg.mode == mii_strap_pkg::MODE_MII_B2B);

  always_comb begin
    next_pinOe       = miiActive ? '1 : '0;                              // [RULE_08] [RULE_14]
    next_pinOut      = miiActive ? rxSource : '0;                        // [RULE_08]
    next_rxClk       = miiActive ? !rxClk : 1'b0;                        // [RULE_08]
    next_txClk       = miiActive ? !txClk : 1'b0;                        // [RULE_09]
    next_txWord      = txWord;
    next_txWordValid = 1'b0;
    if (miiActive && syncTxEn) begin
      next_txWord      = '{en: 1'b1, data: syncTxData};                  // [RULE_13]
      next_txWordValid = 1'b1;
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      pinOe       <= '0;
      pinOut      <= '0;
      rxClk       <= 1'b0;
      txClk       <= 1'b0;
      txWord      <= '0;
      txWordValid <= 1'b0;
    end else begin
      pinOe       <= next_pinOe;
      pinOut      <= next_pinOut;
      rxClk       <= next_rxClk;
      txClk       <= next_txClk;
      txWord      <= next_txWord;
      txWordValid <= next_txWordValid;
    end
  end

  // ***************************
  // interrupt status and pin
  // ***************************
  logic [7:0] next_intPending;
  logic       next_interruptPin;

  always_comb begin
    next_intPending   = (intPending & ~intClear) | (intEvents & intEnable); // [RULE_06]
    next_interruptPin = intPolarityHigh ? (|intPending) : !(|intPending);   // [RULE_05]
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      intPending   <= 8'h00;
      interruptPin <= 1'b1;
    end else begin
      intPending   <= next_intPending;
      interruptPin <= next_interruptPin;
    end
  end

  // ***************************
  // assertions
  // ***************************
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstn);

  property p_addr_capture;
    $rose(strapDone) |-> stationAddress[2:0] ==
      {$past(syncPins.rxd[1]), $past(syncPins.rxd[2]), $past(syncPins.rxd[3])};
  endproperty
  a_addr_capture: assert property (p_addr_capture) else $error("address strap wrong"); // [RULE_01]

  property p_duplex_capture;
    $rose(strapDone) |-> basicControl[8] == $past(syncPins.rxd[0]);
  endproperty
  a_duplex_capture: assert property (p_duplex_capture) else $error("duplex wrong"); // [RULE_02]

  property p_mode_msb;
    $rose(strapDone) |-> interfaceMode[2] == $past(syncPins.rxdv);
  endproperty
  a_mode_msb: assert property (p_mode_msb) else $error("mode msb strap wrong"); // [RULE_03]

  property p_detach_capture;
    $rose(strapDone) |-> basicControl[10] == $past(syncPins.rxer) &&
      cfg.detach == basicControl[10];
  endproperty
  a_detach_capture: assert property (p_detach_capture) else $error("detach wrong"); // [RULE_04]

  property p_int_polarity;
    1 |=> interruptPin == ($past(intPolarityHigh) ? (|$past(intPending)) : !(|$past(intPending)));
  endproperty
  a_int_polarity: assert property (p_int_polarity) else $error("pin level wrong"); // [RULE_05]

  property p_int_set_wins;
    (intEvents[0] && intEnable[0]) |=> intPending[0];
  endproperty
  a_int_set_wins: assert property (p_int_set_wins) else $error("pending event lost"); // [RULE_06]

  property p_addr_high_zero;
    stationAddress[4:3] == 2'b00;
  endproperty
  a_addr_high_zero: assert property (p_addr_high_zero) else $error("high addr set"); // [RULE_12]

  property p_no_drive_early;
    !strapDone |=> pinOe == '0;
  endproperty
  a_no_drive_early: assert property (p_no_drive_early) else $error("driven early"); // [RULE_14]

  property p_drive_after;
    miiActive |=> pinOe == '1 && pinOut == $past(rxSource);
  endproperty
  a_drive_after: assert property (p_drive_after) else $error("mii not driven"); // [RULE_08]

  property p_tx_clock;
    miiActive |=> txClk != $past(txClk);
  endproperty
  a_tx_clock: assert property (p_tx_clock) else $error("transmit clock stalled"); // [RULE_09]

  property p_tx_hold;
    !syncTxEn |=> $stable(txWord) && !txWordValid;
  endproperty
  a_tx_hold: assert property (p_tx_hold) else $error("nibble taken idle"); // [RULE_13]

  property p_reserved;
    strapDone |-> modeReserved == (interfaceMode[1:0] == 2'b11);
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved mode flag wrong"); // [RULE_10]

  c_strap_done: cover property ($rose(strapDone));
  c_tx_word:    cover property (txWordValid ##1 txWordValid);
  c_int_fire:   cover property (intPolarityHigh && interruptPin);
endmodule
`default_nettype wire

// ### logic/mii_strap_pkg.sv
// shared constants and types for the strap loader
`default_nettype none
package mii_strap_pkg;
  // ***************************
  // register map and field positions
  // ***************************
  localparam logic [4:0] BASIC_CTRL_ADDR  = 5'h00;
  localparam logic [4:0] INT_CTRL_ADDR    = 5'h1b;
  localparam logic [4:0] PHY_CTRL2_ADDR   = 5'h1f;
  localparam int         DUPLEX_BIT       = 8;
  localparam int         DETACH_BIT       = 10;
  localparam int         INT_POLARITY_BIT = 9;
  localparam int         INT_WIDTH        = 8;
  // ***************************
  // timing
  // ***************************
  localparam int         CLK_PERIOD_NS    = 100;
  localparam int         SETTLE_TIME_NS   = 300;
  localparam int         SETTLE_CYCLES    = (SETTLE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // ***************************
  // types
  // ***************************
  typedef enum logic [2:0] {
    MODE_MII          = 3'h0,
    MODE_RMII         = 3'h1,
    MODE_SMII         = 3'h2,
    MODE_RSVD3        = 3'h3,
    MODE_MII_PREAMBLE = 3'h4,
    MODE_RMII_B2B     = 3'h5,
    MODE_MII_B2B      = 3'h6,
    MODE_RSVD7        = 3'h7
  } iface_mode_t;

  typedef struct packed {
    logic [3:0] rxd;
    logic       rxdv;
    logic       rxer;
    logic       crs;
    logic       col;
  } strap_pins_t;

  typedef struct packed {
    logic [4:0]  stationAddress;
    logic        duplex;
    iface_mode_t mode;
    logic        detach;
  } strap_cfg_t;

  typedef struct packed {
    logic       en;
    logic [3:0] data;
  } mii_tx_t;

  localparam strap_cfg_t  STRAP_RESET = '{stationAddress: 5'h01, duplex: 1'b1,
                                          mode: MODE_MII, detach: 1'b0};
  localparam logic [15:0] CTRL_RESET  = 16'h0100;
endpackage
`default_nettype wire

// ### logic/strap_sync.sv
// two-stage synchroniser bank for pin inputs
`timescale 1ns/1ps
`default_nettype none
module strap_sync #(
  parameter int WIDTH = 13
) (
  // clock and reset
  input  wire logic             ref_clk,
  input  wire logic             rstn,
  // data
  input  wire logic [WIDTH-1:0] din,
  output logic      [WIDTH-1:0] dout
);
  // ***************************
  // checks
  // ***************************
  if (WIDTH < 1) begin : g_bad_width
    $error("strap_sync width must be at least one");
  end

  // ***************************
  // per-bit stages
  // ***************************
  for (genvar i = 0; i < WIDTH; i++) begin : g_bit
    logic stage1;
    always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
        stage1  <= 1'b0;
        dout[i] <= 1'b0;
      end else begin
        stage1  <= din[i];
        dout[i] <= stage1;
      end
    end
  end
endmodule
`default_nettype wire
